// [logic/hbp_pkg.sv]
// hbp_pkg.sv: constants, types and state layouts of the host bus port
// Notes on behaviour
// - slave port, 32-bit data, registers and FIFOs
// - endian pin low little, high big
// - internal words little endian, port reorders bytes
// - host ties endian pin to address line
// - FIFO pin forces TX writes, RX reads
// - normal mode decodes the base address map
// - reads end on chip select or strobe
// - writes end on chip select or strobe
// - tail of read cut by reset ignored
// - writes discarded until first read after reset
// - TX level visible within 135 ns
// - host waits after write before reading
// - wait may be dummy reads or idle time
// - interrupts monitored, enabled, drive request pin
// - write side effects readable within listed waits
`default_nettype none
package hbp_pkg;
   localparam int DW         = 32;
   localparam int AW         = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int LVL_W      = 6;
   localparam int INT_W      = 3;
   // ----------------------------------------
   // address map
   // ----------------------------------------
   localparam logic [AW-1:0] OFS_RX_DATA   = 8'h00;
   localparam logic [AW-1:0] OFS_TX_DATA   = 8'h20;
   localparam logic [AW-1:0] OFS_INTERRUPT_STATUS_REG   = 8'h58;
   localparam logic [AW-1:0] OFS_INT_EN    = 8'h5C;
   localparam logic [AW-1:0] OFS_BYTE_TEST = 8'h64;
   localparam logic [AW-1:0] OFS_RX_INFO   = 8'h7C;
   localparam logic [AW-1:0] OFS_TX_INFO   = 8'h80;
   localparam logic [DW-1:0] BYTE_TEST_VAL = 32'h87654321;
   localparam int INT_RX     = 0;
   localparam int INT_TX_OVF = 1;
   localparam int INT_WR_DROP = 2;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int WR_RD_WAIT_NS = 315;
   localparam logic [3:0] WR_RD_WAIT_CYC =
      4'((WR_RD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] STROBE_CYC = 4'h3;
   localparam logic [3:0] GAP_CYC    = 4'h2;
   // ----------------------------------------
   // state layouts
   // ----------------------------------------
   typedef struct packed {
      logic             idleSeen;
      logic             wrArmed;
      logic             rdAct;
      logic             wrAct;
      logic [AW-1:0]    addr;
      logic             fifoMode;
      logic [DW-1:0]    wrData;
      logic [DW-1:0]    rdData;
      logic             rdOe;
      logic             push;
      logic [DW-1:0]    pushData;
      logic             pop;
      logic [INT_W-1:0] sts;
      logic [INT_W-1:0] en;
      logic             irq;
      logic [LVL_W-1:0] txLevel;
   } hbp_dev_state_t;
   localparam hbp_dev_state_t DEV_RESET = '0;

   typedef enum logic [1:0] {
      H_IDLE   = 2'b00,
      H_WAIT   = 2'b01,
      H_STROBE = 2'b10,
      H_GAP    = 2'b11
   } hbp_hstate_t;

   typedef struct packed {
      hbp_hstate_t   state;
      logic          booted;
      logic          cmdReady;
      logic          cs_n;
      logic          rd_n;
      logic          wr_n;
      logic [AW-1:0] addr;
      logic          endSel;
      logic          fifoSel;
      logic [DW-1:0] dOut;
      logic          dOe;
      logic          isWr;
      logic [3:0]    cnt;
      logic [3:0]    sinceWr;
      logic          rspValid;
      logic [DW-1:0] rspData;
      logic          irq;
   } hbp_host_state_t;
   localparam hbp_host_state_t HOST_RESET = '{state: H_IDLE, cs_n: 1'h1,
      rd_n: 1'h1, wr_n: 1'h1, sinceWr: WR_RD_WAIT_CYC, default: '0};

   // little endian passes, big endian reverses the byte lanes
   function automatic logic [DW-1:0] hbp_swap(input logic [DW-1:0] d,
                                              input logic          big);
      hbp_swap = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
   endfunction
endpackage
`default_nettype wire

// [logic/hbp_if.sv]
// hbp_if.sv: SRAM-like host bus between host end and device end
`timescale 1ns/1ns
`default_nettype none
interface hbp_if;
   logic                    chipSelect_n;
   logic                    readStrobe_n;
   logic                    writeStrobe_n;
   logic [hbp_pkg::AW-1:0]  addr;
   logic                    endianSel;
   logic                    fifoSel;
   logic [hbp_pkg::DW-1:0]  hostData;
   logic                    hostDataOe;
   logic [hbp_pkg::DW-1:0]  devData;
   logic                    devDataOe;
   logic                    irq;
   logic                    txSpace;
   logic [hbp_pkg::DW-1:0]  busData;

   // shared data wire resolved from the two enables
   assign busData = devDataOe ? devData : (hostDataOe ? hostData : '0);

   modport device (
      input  chipSelect_n, readStrobe_n, writeStrobe_n, addr, endianSel,
             fifoSel, busData,
      output devData, devDataOe, irq, txSpace
   );
   modport host (
      output chipSelect_n, readStrobe_n, writeStrobe_n, addr, endianSel,
             fifoSel, hostData, hostDataOe,
      input  busData, irq, txSpace
   );
endinterface
`default_nettype wire

// [logic/hbp_device.sv]
// hbp_device.sv: device end of the host bus port with its data FIFOs
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// fifo with registered output stage
// ----------------------------------------
module hbp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rst_b,
   input  wire logic                     inValid,
   input  wire logic [WIDTH-1:0]         inData,
   output logic                          inReady,
   output logic                          outValid,
   output logic [WIDTH-1:0]              outData,
   input  wire logic                     outReady,
   output logic [$clog2(DEPTH):0]        level
);
   import hbp_pkg::*;
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wrPtr;
      logic [PW-1:0]               rdPtr;
      logic [PW:0]                 cnt;
      logic                        inReady;
      logic                        outValid;
      logic [WIDTH-1:0]            outData;
   } hbp_fifo_state_t;

   hbp_fifo_state_t fifo_reg;
   hbp_fifo_state_t fifo_next;

   always_comb
   begin
      fifo_next = fifo_reg;
      if (fifo_reg.outValid && outReady)
      begin
         fifo_next.outValid = 1'h0;
      end
      if (inValid && fifo_reg.inReady)
      begin
         fifo_next.mem[fifo_reg.wrPtr] = inData;
         fifo_next.wrPtr = fifo_reg.wrPtr + 1'h1;
         fifo_next.cnt = fifo_next.cnt + 1'h1;
      end
      // output stage refills from storage in the cycle it empties
      if (!fifo_next.outValid && fifo_reg.cnt != '0)
      begin
         fifo_next.outData = fifo_reg.mem[fifo_reg.rdPtr];
         fifo_next.outValid = 1'h1;
         fifo_next.rdPtr = fifo_reg.rdPtr + 1'h1;
         fifo_next.cnt = fifo_next.cnt - 1'h1;
      end
      // ready is registered, so it looks at the count after this edge
      fifo_next.inReady = fifo_next.cnt < (PW+1)'(DEPTH);
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fifo_reg <= '0;
      end
      else
      begin
         fifo_reg <= fifo_next;
      end
   end

   assign inReady  = fifo_reg.inReady;
   assign outValid = fifo_reg.outValid;
   assign outData  = fifo_reg.outData;
   assign level    = fifo_reg.cnt;
endmodule

// ----------------------------------------
// device end
// ----------------------------------------
module hbp_device (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   hbp_if.device                        bus,
   output logic [hbp_pkg::DW-1:0]       txData,
   output logic                         txValid,
   input  wire logic                    txReady,
   input  wire logic [hbp_pkg::DW-1:0]  rxData,
   input  wire logic                    rxValid,
   output logic                         rxReady
);
   import hbp_pkg::*;

   hbp_dev_state_t       dev_reg;
   hbp_dev_state_t       dev_next;
   logic                 txInReady;
   logic [LVL_W-1:0]     txCnt;
   logic                 rxOutValid;
   logic [DW-1:0]        rxOutData;
   logic [LVL_W-1:0]     rxCnt;
   logic                 rdNow;
   logic                 wrNow;
   logic [DW-1:0]        rxWord;
   logic [DW-1:0]        word;
   logic [INT_W-1:0]     setV;
   logic [INT_W-1:0]     clrV;
   logic                 toTx;

   // ----------------------------------------
   // data FIFOs
   // ----------------------------------------
   hbp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) txFifo (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .inValid  (dev_reg.push),
      .inData   (dev_reg.pushData),
      .inReady  (txInReady),
      .outValid (txValid),
      .outData  (txData),
      .outReady (txReady),
      .level    (txCnt)
   );

   hbp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) rxFifo (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .inValid  (rxValid),
      .inData   (rxData),
      .inReady  (rxReady),
      .outValid (rxOutValid),
      .outData  (rxOutData),
      .outReady (dev_reg.pop),
      .level    (rxCnt)
   );

   // ----------------------------------------
   // read data select
   // ----------------------------------------
   always_comb
   begin
      rxWord = rxOutValid ? rxOutData : '0;
      case (bus.addr)
         OFS_RX_DATA:   word = rxWord;
         OFS_INTERRUPT_STATUS_REG:   word = {{(DW-INT_W){1'h0}}, dev_reg.sts};
         OFS_INT_EN:    word = {{(DW-INT_W){1'h0}}, dev_reg.en};
         OFS_BYTE_TEST: word = BYTE_TEST_VAL;
         OFS_RX_INFO:   word = {{(DW-LVL_W){1'h0}}, rxCnt};
         OFS_TX_INFO:   word = {{(DW-LVL_W){1'h0}}, dev_reg.txLevel};
         default:       word = '0;
      endcase
      if (bus.fifoSel)
      begin
         word = rxWord;
      end
   end

   // ----------------------------------------
   // access sequencing
   // ----------------------------------------
   always_comb
   begin
      rdNow = !bus.chipSelect_n && !bus.readStrobe_n;
      wrNow = !bus.chipSelect_n && !bus.writeStrobe_n;
      toTx  = dev_reg.fifoMode || dev_reg.addr == OFS_TX_DATA;
      setV  = '0;
      clrV  = '0;
      dev_next = dev_reg;
      dev_next.push = 1'h0;
      dev_next.pop = 1'h0;
      // a read still open when reset lifts is not served at all
      if (!rdNow)
      begin
         dev_next.idleSeen = 1'h1;
      end
      dev_next.rdAct = rdNow && (dev_reg.rdAct || dev_reg.idleSeen);
      dev_next.wrAct = wrNow;
      // read data is snapshot at strobe start, held until the end
      if (rdNow && !dev_reg.rdAct && dev_reg.idleSeen)
      begin
         dev_next.addr = bus.addr;
         dev_next.fifoMode = bus.fifoSel;
         dev_next.rdData = hbp_swap(word, bus.endianSel);
      end
      dev_next.rdOe = dev_next.rdAct;
      // read completes when either strobe or chip select rises
      if (dev_reg.rdAct && !rdNow)
      begin
         dev_next.wrArmed = 1'h1;
         if (dev_reg.fifoMode || dev_reg.addr == OFS_RX_DATA)
         begin
            dev_next.pop = rxOutValid;
         end
      end
      if (wrNow)
      begin
         dev_next.addr = bus.addr;
         dev_next.fifoMode = bus.fifoSel;
         dev_next.wrData = hbp_swap(bus.busData, bus.endianSel);
      end
      // write commits on the rising edge of strobe or chip select
      if (dev_reg.wrAct && !wrNow)
      begin
         if (!dev_reg.wrArmed)
         begin
            setV[INT_WR_DROP] = 1'h1;
         end
         else if (toTx)
         begin
            // no wait state on this bus: a full FIFO drops the word
            if (txInReady)
            begin
               dev_next.push = 1'h1;
               dev_next.pushData = dev_reg.wrData;
            end
            else
            begin
               setV[INT_TX_OVF] = 1'h1;
            end
         end
         else if (dev_reg.addr == OFS_INTERRUPT_STATUS_REG)
         begin
            clrV = dev_reg.wrData[INT_W-1:0];
         end
         else if (dev_reg.addr == OFS_INT_EN)
         begin
            dev_next.en = dev_reg.wrData[INT_W-1:0];
         end
      end
      if (rxValid && rxReady)
      begin
         setV[INT_RX] = 1'h1;
      end
      // a new event outranks a clear landing in the same cycle
      dev_next.sts = (dev_reg.sts & ~clrV) | setV;
      dev_next.irq = |(dev_next.sts & dev_next.en);
      // level reaches the info word three cycles after the strobe ends
      dev_next.txLevel = txCnt + LVL_W'(txValid);
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dev_reg <= DEV_RESET;
      end
      else
      begin
         dev_reg <= dev_next;
      end
   end

   assign bus.devData   = dev_reg.rdData;
   assign bus.devDataOe = dev_reg.rdOe;
   assign bus.irq       = dev_reg.irq;
   assign bus.txSpace   = txInReady;
endmodule
`default_nettype wire

// [logic/hbp_host.sv]
// hbp_host.sv: host end that runs bus cycles for a command port
`timescale 1ns/1ns
`default_nettype none
module hbp_host (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   hbp_if.host                          bus,
   input  wire logic                    cmdValid,
   input  wire logic                    cmdWrite,
   input  wire logic [hbp_pkg::AW+1:0]  cmdAddr,
   input  wire logic [hbp_pkg::DW-1:0]  cmdData,
   output logic                         cmdReady,
   output logic                         rspValid,
   output logic [hbp_pkg::DW-1:0]       rspData,
   output logic                         hostIrq
);
   import hbp_pkg::*;

   hbp_host_state_t host_reg;
   hbp_host_state_t host_next;
   logic            toTx;

   always_comb
   begin
      toTx = host_reg.fifoSel || host_reg.addr == OFS_TX_DATA;
      host_next = host_reg;
      host_next.rspValid = 1'h0;
      host_next.irq = bus.irq;
      if (host_reg.sinceWr != WR_RD_WAIT_CYC)
      begin
         host_next.sinceWr = host_reg.sinceWr + 1'h1;
      end
      case (host_reg.state)
         H_IDLE:
         begin
            // first cycle after reset is a dummy read so writes count
            if (!host_reg.booted)
            begin
               host_next.addr = OFS_BYTE_TEST;
               host_next.endSel = 1'h0;
               host_next.fifoSel = 1'h0;
               host_next.isWr = 1'h0;
               host_next.state = H_WAIT;
            end
            else if (cmdValid && host_reg.cmdReady)
            begin
               host_next.addr = cmdAddr[AW-1:0];
               host_next.endSel = cmdAddr[AW];
               host_next.fifoSel = cmdAddr[AW+1];
               host_next.isWr = cmdWrite;
               host_next.dOut = cmdData;
               host_next.state = H_WAIT;
            end
         end
         H_WAIT:
         begin
            // idle time stands in for dummy reads; covers worst register
            if (host_reg.isWr ? (!toTx || bus.txSpace)
                              : host_reg.sinceWr == WR_RD_WAIT_CYC)
            begin
               host_next.cs_n = 1'h0;
               host_next.rd_n = host_reg.isWr;
               host_next.wr_n = !host_reg.isWr;
               host_next.dOe = host_reg.isWr;
               host_next.cnt = '0;
               host_next.state = H_STROBE;
            end
         end
         H_STROBE:
         begin
            host_next.cnt = host_reg.cnt + 1'h1;
            if (host_reg.cnt == STROBE_CYC - 1'h1)
            begin
               host_next.cs_n = 1'h1;
               host_next.rd_n = 1'h1;
               host_next.wr_n = 1'h1;
               host_next.dOe = 1'h0;
               host_next.cnt = '0;
               host_next.state = H_GAP;
               if (host_reg.isWr)
               begin
                  host_next.sinceWr = '0;
               end
               else
               begin
                  host_next.rspData = bus.busData;
                  host_next.rspValid = host_reg.booted;
                  host_next.booted = 1'h1;
               end
            end
         end
         H_GAP:
         begin
            host_next.cnt = host_reg.cnt + 1'h1;
            if (host_reg.cnt == GAP_CYC - 1'h1)
            begin
               host_next.state = H_IDLE;
            end
         end
         default:
         begin
            host_next.state = H_IDLE;
         end
      endcase
      host_next.cmdReady = host_next.state == H_IDLE && host_next.booted;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         host_reg <= HOST_RESET;
      end
      else
      begin
         host_reg <= host_next;
      end
   end

   assign bus.chipSelect_n  = host_reg.cs_n;
   assign bus.readStrobe_n  = host_reg.rd_n;
   assign bus.writeStrobe_n = host_reg.wr_n;
   assign bus.addr          = host_reg.addr;
   assign bus.endianSel     = host_reg.endSel;
   assign bus.fifoSel       = host_reg.fifoSel;
   assign bus.hostData      = host_reg.dOut;
   assign bus.hostDataOe    = host_reg.dOe;
   assign cmdReady          = host_reg.cmdReady;
   assign rspValid          = host_reg.rspValid;
   assign rspData           = host_reg.rspData;
   assign hostIrq           = host_reg.irq;
endmodule
`default_nettype wire

// [dv/hbp_assertions.sv]
// hbp_assertions.sv: protocol checks on the bus between host and device
`timescale 1ns/1ns
`default_nettype none
module hbp_assertions (
   input wire logic                   clk_sys,
   input wire logic                   rst_b,
   input wire logic                   chipSelect_n,
   input wire logic                   readStrobe_n,
   input wire logic                   writeStrobe_n,
   input wire logic [hbp_pkg::AW-1:0] addr,
   input wire logic                   endianSel,
   input wire logic                   fifoSel,
   input wire logic [hbp_pkg::DW-1:0] hostData,
   input wire logic                   hostDataOe,
   input wire logic [hbp_pkg::DW-1:0] devData,
   input wire logic                   devDataOe
);
   import hbp_pkg::*;
   // ----------------------------------------
   // cycles since the last write ended
   // ----------------------------------------
   logic [3:0] sinceWr_reg;
   logic [3:0] sinceWr_next;
   logic       wrPrev_reg;
   always_comb
   begin
      sinceWr_next = sinceWr_reg;
      if (writeStrobe_n && !wrPrev_reg)
         sinceWr_next = 4'h0;
      else if (sinceWr_reg != 4'hF)
         sinceWr_next = sinceWr_reg + 4'h1;
   end
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sinceWr_reg <= 4'hF;
         wrPrev_reg  <= 1'b1;
      end
      else
      begin
         sinceWr_reg <= sinceWr_next;
         wrPrev_reg  <= writeStrobe_n;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence rd_start;
      $fell(readStrobe_n) && !chipSelect_n;
   endsequence
   sequence wr_start;
      $fell(writeStrobe_n) && !chipSelect_n;
   endsequence
   a_no_bus_fight: assert property (!(devDataOe && hostDataOe))
      else $error("both ends drive the data bus");
   a_oe_needs_read: assert property (devDataOe |-> $past(readStrobe_n) == 1'b0)
      else $error("device drives without a read");
   a_read_answer: assert property (rd_start |=> devDataOe)
      else $error("read got no answer");
   a_read_release: assert property ($rose(readStrobe_n) |=> !devDataOe)
      else $error("device holds bus after read");
   a_byte_test_value: assert property (rd_start ##0
      (addr == OFS_BYTE_TEST && !fifoSel) |=>
      devData == (endianSel ? 32'h21436587 : BYTE_TEST_VAL))
      else $error("byte test value wrong");
   a_read_width: assert property (rd_start |->
      !readStrobe_n[*3] ##1 readStrobe_n)
      else $error("read strobe width wrong");
   a_write_hold: assert property (wr_start |->
      (hostDataOe && !chipSelect_n)[*3] ##1 writeStrobe_n)
      else $error("write cycle not held");
   a_write_data: assert property (wr_start |=> $stable(hostData)[*2])
      else $error("write data moved");
   a_cs_gap: assert property ($rose(chipSelect_n) |-> chipSelect_n[*2])
      else $error("gap between accesses too short");
   // counter starts one edge after the strobe rises, hence the minus one
   a_read_after_wr: assert property (rd_start |->
      sinceWr_reg >= WR_RD_WAIT_CYC - 4'h1)
      else $error("read too soon after write");
endmodule
`default_nettype wire

// [dv/hbp_test.sv]
// hbp_test.sv: self-checking bench with host end facing device end
`timescale 1ns/1ns
`default_nettype none
module hbp_test;
   import hbp_pkg::*;
   logic          clk_sys = 1'b0;
   logic          rst_b = 1'b0;
   logic          rst2_b = 1'b0;
   logic          cmdValid = 1'b0;
   logic          cmdWrite = 1'b0;
   logic [AW+1:0] cmdAddr = '0;
   logic [DW-1:0] cmdData = '0;
   logic          cmdReady, rspValid, hostIrq, txValid, txValid2, rxReady;
   logic [DW-1:0] rspData, txData, txData2, r;
   logic          txReady = 1'b0;
   logic          rxValid = 1'b0;
   logic [DW-1:0] rxData = '0;
   int            fail_count = 0;
   int            check_count = 0;

   hbp_if bus1 ();
   hbp_if bus2 ();
   always #20 clk_sys = ~clk_sys;

   hbp_host i_hbp_host (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus1),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
      .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
      .rspData(rspData), .hostIrq(hostIrq));
   hbp_device i_hbp_device (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus1),
      .txData(txData), .txValid(txValid), .txReady(txReady),
      .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady));
   // second device faces the bench, which breaks the host's rules
   hbp_device i_hbp_device_b (.clk_sys(clk_sys), .rst_b(rst2_b),
      .bus(bus2), .txData(txData2), .txValid(txValid2), .txReady(1'b0),
      .rxData(32'h0), .rxValid(1'b0), .rxReady());
   hbp_assertions i_hbp_assertions (.clk_sys(clk_sys), .rst_b(rst_b),
      .chipSelect_n(bus1.chipSelect_n), .readStrobe_n(bus1.readStrobe_n),
      .writeStrobe_n(bus1.writeStrobe_n), .addr(bus1.addr),
      .endianSel(bus1.endianSel), .fifoSel(bus1.fifoSel),
      .hostData(bus1.hostData), .hostDataOe(bus1.hostDataOe),
      .devData(bus1.devData), .devDataOe(bus1.devDataOe));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [DW-1:0] e,
                      input logic [DW-1:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // one command through the host end; read data lands in r
   task automatic cmd(input logic w, input logic [AW+1:0] a,
                      input logic [DW-1:0] d);
      int n;
      for (n = 0; cmdReady !== 1'b1 && n < 300; n++) cyc(1);
      chk("cmdReady", 32'h1, {31'h0, cmdReady});
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdAddr  = a;
      cmdData  = d;
      cyc(1);
      cmdValid = 1'b0;
      for (n = 0; !w && rspValid !== 1'b1 && n < 300; n++) cyc(1);
      if (!w)
         chk("rspValid", 32'h1, {31'h0, rspValid});
      r = rspData;
   endtask
   task automatic pop(input logic [DW-1:0] e);
      int n;
      for (n = 0; txValid !== 1'b1 && n < 50; n++) cyc(1);
      chk("txData", e, txData);
      txReady = 1'b1;
      cyc(1);
      txReady = 1'b0;
      cyc(1);
   endtask
   task automatic push(input logic [DW-1:0] d);
      int n;
      for (n = 0; rxReady !== 1'b1 && n < 50; n++) cyc(1);
      rxValid = 1'b1;
      rxData  = d;
      cyc(1);
      rxValid = 1'b0;
   endtask
   // raw bus cycle on the second device, strobe held three cycles
   task automatic raw(input logic w, input logic [AW-1:0] a,
                      input logic [DW-1:0] d);
      bus2.addr          = a;
      bus2.hostData      = d;
      bus2.hostDataOe    = w;
      bus2.chipSelect_n  = 1'b0;
      bus2.readStrobe_n  = w;
      bus2.writeStrobe_n = !w;
      cyc(3);
      r = bus2.busData;
      bus2.chipSelect_n  = 1'b1;
      bus2.readStrobe_n  = 1'b1;
      bus2.writeStrobe_n = 1'b1;
      bus2.hostDataOe    = 1'b0;
      cyc(2);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_cases;
      bus2.chipSelect_n = 1'b0;
      bus2.readStrobe_n = 1'b0;
      cyc(1);
      rst2_b = 1'b1;
      cyc(3);
      chk("devDataOe", 32'h0, {31'h0, bus2.devDataOe});
      bus2.chipSelect_n = 1'b1;
      bus2.readStrobe_n = 1'b1;
      cyc(2);
      raw(1'b1, OFS_TX_DATA, 32'h0BADF00D);
      cyc(3);
      chk("txValid", 32'h0, {31'h0, txValid2});
      raw(1'b0, OFS_BYTE_TEST, 32'h0);
      chk("byteTest", BYTE_TEST_VAL, r);
      raw(1'b1, OFS_TX_DATA, 32'h600DCAFE);
      cyc(3);
      chk("txData", 32'h600DCAFE, txData2);
      raw(1'b0, OFS_INTERRUPT_STATUS_REG, 32'h0);
      chk("intStatus", 32'h4, r);
      $display("test reset_cases done");
   endtask
   task automatic t_byte_order;
      cmd(1'b0, 10'h064, 32'h0);
      chk("byteTestLe", 32'h87654321, r);
      cmd(1'b0, 10'h164, 32'h0);
      chk("byteTestBe", 32'h21436587, r);
      cmd(1'b0, 10'h0F0, 32'h0);
      chk("unmapped", 32'h0, r);
      $display("test byte_order done");
   endtask
   // far side stalls while the TX buffer fills to refusal
   task automatic t_tx_fill;
      int i;
      cmd(1'b1, 10'h020, 32'hA1B2C3D4);
      cmd(1'b1, 10'h120, 32'hA1B2C3D4);
      cmd(1'b1, 10'h264, 32'h000000F5);
      for (i = 3; i <= FIFO_DEPTH; i++) cmd(1'b1, 10'h020, DW'(i));
      // a write returns at acceptance; space drops six edges later
      cyc(8);
      chk("txSpace", 32'h0, {31'h0, bus1.txSpace});
      cmd(1'b0, 10'h080, 32'h0);
      chk("txLevel", DW'(FIFO_DEPTH + 1), r);
      pop(32'hA1B2C3D4);
      pop(32'hD4C3B2A1);
      pop(32'h000000F5);
      for (i = 3; i <= FIFO_DEPTH; i++) pop(DW'(i));
      cyc(4);
      chk("txSpace", 32'h1, {31'h0, bus1.txSpace});
      cmd(1'b0, 10'h080, 32'h0);
      chk("txLevel", 32'h0, r);
      $display("test tx_fill done");
   endtask
   task automatic t_rx_irq;
      int n;
      cmd(1'b1, 10'h05C, 32'h1);
      push(32'h11223344);
      for (n = 0; hostIrq !== 1'b1 && n < 10; n++) cyc(1);
      chk("hostIrq", 32'h1, {31'h0, hostIrq});
      cmd(1'b0, 10'h05C, 32'h0);
      chk("intEnable", 32'h1, r);
      cmd(1'b0, 10'h000, 32'h0);
      chk("rxWord", 32'h11223344, r);
      push(32'h55667788);
      cmd(1'b0, 10'h364, 32'h0);
      chk("rxDirectBe", 32'h88776655, r);
      cmd(1'b1, 10'h058, 32'h7);
      cmd(1'b1, 10'h05C, 32'h0);
      cyc(4);
      chk("hostIrq", 32'h0, {31'h0, hostIrq});
      push(32'h99AABBCC);
      cmd(1'b0, 10'h058, 32'h0);
      chk("intStatus", 32'h1, r);
      chk("hostIrq", 32'h0, {31'h0, hostIrq});
      push(32'h13572468);
      cmd(1'b0, 10'h07C, 32'h0);
      chk("rxLevel", 32'h1, r);
      cmd(1'b0, 10'h000, 32'h0);
      chk("rxWord", 32'h99AABBCC, r);
      $display("test rx_irq done");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      bus2.chipSelect_n  = 1'b1;
      bus2.readStrobe_n  = 1'b1;
      bus2.writeStrobe_n = 1'b1;
      bus2.addr          = '0;
      bus2.endianSel     = 1'b0;
      bus2.fifoSel       = 1'b0;
      bus2.hostData      = '0;
      bus2.hostDataOe    = 1'b0;
      cyc(4);
      rst_b = 1'b1;
      t_reset_cases;
      t_byte_order;
      t_tx_fill;
      t_rx_irq;
      end_of_test;
   end
   // whole run needs well under 3000 cycles
   initial
   begin
      #400000;
      fail_count++;
      end_of_test;
   end
endmodule
`default_nettype wire
